// ### testbench/fps_properties.sv
// Port checker for the serializer
`timescale 1ns/1ps
// ========
// Checker
module fps_properties (
  input wire logic i_clk_sys, // Clock
  input wire logic i_rst_n, // Reset
  input wire logic i_sync, // Sync
  input wire logic i_mode_eight, // Mode
  input wire logic o_serial_line_out, // Serial
  input wire logic o_clock_quarter_out, // Clock / 4
  input wire logic o_clock_eighth_out, // Clock / 8
  input wire logic o_load_pulse // Load
);
  logic low_val;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n || i_sync);
  // Low-phase serial value; a rising edge must leave it alone
  always_ff @(posedge i_clk_sys) low_val <= o_serial_line_out;
  property p_ser_edge;
    @(negedge i_clk_sys) disable iff (!i_rst_n) o_serial_line_out == low_val;
  endproperty
  a_ser_edge: assert property (p_ser_edge) else $error("serial edge");
  property p_quarter;
    $changed(o_clock_quarter_out) |=> $stable(o_clock_quarter_out)
      ##1 $changed(o_clock_quarter_out);
  endproperty
  a_quarter: assert property (p_quarter) else $error("quarter");
  property p_eighth;
    i_mode_eight && $changed(o_clock_eighth_out) |=>
      $stable(o_clock_eighth_out)[*3] ##1 $changed(o_clock_eighth_out);
  endproperty
  a_eighth: assert property (p_eighth) else $error("eighth");
  property p_div_step;
    $changed(o_clock_eighth_out) |-> $fell(o_clock_quarter_out);
  endproperty
  a_div_step: assert property (p_div_step) else $error("divider");
  property p_load4;
    !i_mode_eight && o_load_pulse |=> !o_load_pulse[*3] ##1 o_load_pulse;
  endproperty
  a_load4: assert property (p_load4) else $error("load four");
  property p_load8;
    i_mode_eight && o_load_pulse |=> !o_load_pulse[*7] ##1 o_load_pulse;
  endproperty
  a_load8: assert property (p_load8) else $error("load eight");
  // Sync must hold dividers and loads cleared
  property p_sync_clr;
    disable iff (!i_rst_n) i_sync[*2] |->
      !o_clock_quarter_out && !o_clock_eighth_out && !o_load_pulse;
  endproperty
  a_sync_clr: assert property (p_sync_clr) else $error("sync");
  property p_restart;
    disable iff (!i_rst_n) $fell(i_sync) |-> ##[1:12] o_load_pulse;
  endproperty
  a_restart: assert property (p_restart) else $error("restart");
endmodule
bind fps_serializer fps_properties fps_properties_inst (.i_clk_sys,
  .i_rst_n, .i_sync, .i_mode_eight, .o_serial_line_out,
  .o_clock_quarter_out, .o_clock_eighth_out, .o_load_pulse);

// ### testbench/fps_word_source.sv
// Word source feeding the serializer input side
`timescale 1ns/1ps
// ========
// Source
module fps_word_source (
  input wire logic i_clk_sys, // Clock
  input wire logic i_en, // Offer words
  input wire logic i_ready, // Space left
  output logic [3:0] o_data, // Word
  output logic o_valid, // Word offered
  output logic o_cascade // Cascade bit
);
  logic [31:0] st = 32'h445053F4;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction
  initial {o_data, o_valid, o_cascade} = 6'h00;
  // Gap after each offer lets the late ready catch up, so none is refused
  always @(negedge i_clk_sys) begin
    st = xs(st);
    o_cascade <= st[0];
    o_valid <= !o_valid && i_en && i_ready;
    if (!o_valid) o_data <= (st[4:1] == 4'h0) ? 4'h9 : st[4:1];
  end
endmodule

// ### testbench/test_fps_serializer.sv
// Self-checking bench for the serializer
`timescale 1ns/1ps
// ========
// Bench
module test_fps_serializer;
  logic i_clk_sys, i_rst_n, i_sync, i_mode_eight, en, cas, valid, ready;
  logic ser, ld, armed, stalled;
  logic [3:0] data, sh;
  logic [3:0] exp_q[$];
  int n_fail = 0, cmp_count = 0, nld = 0;
  fps_serializer fps_serializer_inst (.i_clk_sys, .i_rst_n, .i_sync,
    .i_mode_eight, .i_cascade_serial_in(cas), .i_parallel_word_in(data),
    .i_word_valid(valid), .o_word_ready(ready), .o_serial_line_out(ser),
    .o_clock_quarter_out(), .o_clock_eighth_out(), .o_load_pulse(ld));
  fps_word_source fps_word_source_inst (.i_clk_sys, .i_en(en),
    .i_ready(ready), .o_data(data), .o_valid(valid), .o_cascade(cas));
  task automatic cmp(input logic [3:0] got, input logic [3:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Model: taken words queue up; each load closes the previous nibble
  always @(posedge i_clk_sys) begin
    if (valid && ready) exp_q.push_back(data);
    if (armed && !ready) stalled = 1'b1;
    if (ld) nld++;
    if (ld && armed && sh != 4'h0) cmp(sh, exp_q.pop_front());
    else if (ld && armed && exp_q.size() == 0) cmp(sh, 4'h0);
    sh = {ser, sh[3:1]};
  end
  initial begin
    i_clk_sys = 1'b0;
    forever #50 i_clk_sys = ~i_clk_sys;
  end
  // Run needs 358 cycles; allow over eight times that
  initial begin
    #300000;
    n_fail++;
    end_sim();
  end
  initial begin
    {i_rst_n, i_sync, i_mode_eight, en, armed, stalled} = 6'h00;
    repeat (6) @(negedge i_clk_sys);
    i_rst_n = 1'b1;
    armed = 1'b1;
    en = 1'b1;
    // Fill faster than the drain, then let the buffer run dry
    repeat (160) @(negedge i_clk_sys);
    cmp({3'h0, stalled}, 4'h1);
    en = 1'b0;
    repeat (100) @(negedge i_clk_sys);
    cmp(4'(exp_q.size()), 4'h0);
    armed = 1'b0;
    i_sync = 1'b1;
    i_mode_eight = 1'b1;
    repeat (4) @(negedge i_clk_sys);
    i_sync = 1'b0;
    en = 1'b1;
    repeat (8) @(negedge i_clk_sys);
    nld = 0;
    repeat (80) @(negedge i_clk_sys);
    cmp(4'(nld), 4'hA);
    end_sim();
  end
endmodule

// ### verilog/fps_fifo.sv
// Parameterised synchronous FIFO with registered read data
`timescale 1ns/1ps
module fps_fifo #(
  parameter int WIDTH = 4,
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  input wire logic i_clk_sys, // System clock
  input wire logic i_rst_n,   // Asynchronous reset, active low
  fps_fifo_if.fifo port       // Fill and drain sides
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic [WIDTH-1:0] rd_data;
  logic rd_valid;
  wire full = (wr_ptr[AW] != rd_ptr[AW]) &&
              (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  wire empty = (wr_ptr == rd_ptr);
  wire do_wr = port.in_valid && !full;
  // Output stage is a register; refill it when drained or empty
  wire take_out = !rd_valid || port.out_ready;
  wire do_rd = take_out && !empty;

  assign port.in_ready = !full;
  assign port.out_data = rd_data;
  assign port.out_valid = rd_valid;

  // =====================================================
  // Storage array, no reset so it maps to plain memory
  always_ff @(posedge i_clk_sys) begin
    if (do_wr) begin
      mem[wr_ptr[AW-1:0]] <= port.in_data;
    end
  end

  // =====================================================
  // Pointers and registered read port
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      rd_data <= '0;
      rd_valid <= 1'b0;
    end else begin
      if (do_wr) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (do_rd) begin
        rd_ptr <= rd_ptr + 1'b1;
        rd_data <= mem[rd_ptr[AW-1:0]];
      end
      if (take_out) begin
        rd_valid <= !empty;
      end
    end
  end
endmodule

// ### verilog/fps_fifo_if.sv
// Interface carrying the word stream between the serializer and its FIFO
`timescale 1ns/1ps
interface fps_fifo_if;
  logic [3:0] in_data;
  logic in_valid;
  logic in_ready;
  logic [3:0] out_data;
  logic out_valid;
  logic out_ready;
  modport fifo (
    input in_data, in_valid, out_ready,
    output in_ready, out_data, out_valid
  );
  modport user (
    output in_data, in_valid, out_ready,
    input in_ready, out_data, out_valid
  );
endinterface

// ### verilog/fps_pkg.sv
// Package with constants and types for the four-bit parallel serializer
package fps_pkg;
  localparam int WORD_W = 4;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_AW = 4;
  localparam logic [2:0] DIV_RESET = 3'h0;
  localparam logic [2:0] LOAD_PHASE = 3'h0;
  localparam logic [2:0] LAST_PHASE_4 = 3'h3;
  localparam logic [2:0] LAST_PHASE_8 = 3'h7;
  localparam logic [3:0] SHIFT_RESET = 4'h0;
  typedef enum logic {FPS_WAIT, FPS_RUN} fps_state_type;
endpackage

// ### verilog/fps_serializer.sv
// Four-bit parallel to serial converter with clock dividers and cascade input
`timescale 1ns/1ps
module fps_serializer
  import fps_pkg::*;
(
  input wire logic i_clk_sys,                  // System clock, 10 MHz
  input wire logic i_rst_n,                    // Async reset, active low
  input wire logic i_sync,                     // Async sync, active high
  input wire logic i_mode_eight,               // High selects 8-bit mode
  input wire logic i_cascade_serial_in,        // Serial input from cascade
  input wire logic [fps_pkg::WORD_W-1:0] i_parallel_word_in, // Word data
  input wire logic i_word_valid,               // Word offered
  output logic o_word_ready,                   // FIFO can take a word
  output logic o_serial_line_out,              // Serial NRZ output
  output logic o_clock_quarter_out,            // Clock divided by four
  output logic o_clock_eighth_out,             // Clock divided by eight in 8-bit mode, held low in 4-bit mode
  output logic o_load_pulse                    // One cycle on each load
);
  import fps_pkg::*;

  fps_fifo_if fifo_bus ();
  fps_state_type state;
  fps_state_type next_state;
  logic [2:0] div_count;
  logic [3:0] shift_chain;
  logic [3:0] next_shift;
  logic sync_meta;
  logic sync_hold;
  logic mode_meta;
  logic mode_sync;
  logic cas_meta;
  logic cas_sync;
  logic ready_reg;
  logic serial_neg;

  // =====================================================
  // Input synchronisers; sync also clears the divider directly
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mode_meta <= 1'b0;
      mode_sync <= 1'b0;
      cas_meta <= 1'b0;
      cas_sync <= 1'b0;
    end else begin
      mode_meta <= i_mode_eight;
      mode_sync <= mode_meta;
      cas_meta <= i_cascade_serial_in;
      cas_sync <= cas_meta;
    end
  end

  // Release of sync is synchronised so the divider restarts cleanly
  always_ff @(posedge i_clk_sys or negedge i_rst_n or posedge i_sync) begin
    if (!i_rst_n) begin
      sync_meta <= 1'b1;
      sync_hold <= 1'b1;
    end else if (i_sync) begin
      sync_meta <= 1'b1;
      sync_hold <= 1'b1;
    end else begin
      sync_meta <= 1'b0;
      sync_hold <= sync_meta;
    end
  end

  // =====================================================
  // Load sequencing decode
  wire [2:0] last_phase = mode_sync ? LAST_PHASE_8 : LAST_PHASE_4;
  wire load_now = (state == FPS_RUN) && (div_count == LOAD_PHASE);
  wire wrap = (div_count == last_phase);
  wire [2:0] next_div = wrap ? DIV_RESET : div_count + 3'h1;

  assign fifo_bus.in_data = i_parallel_word_in;
  assign fifo_bus.in_valid = i_word_valid;
  // A waiting word is consumed at each load so back-pressure follows the line rate
  assign fifo_bus.out_ready = load_now;

  // Load captures the whole word, else shift down filling from cascade
  always_comb begin
    next_shift = shift_chain;
    if (load_now) begin
      next_shift = fifo_bus.out_valid ? fifo_bus.out_data
                                      : SHIFT_RESET;
    end else if (state == FPS_RUN) begin
      next_shift = {cas_sync, shift_chain[3:1]};
    end
  end

  always_comb begin
    next_state = FPS_RUN;
  end

  // =====================================================
  // Divider and load sequencer, reset at once by sync
  always_ff @(posedge i_clk_sys or negedge i_rst_n or posedge i_sync) begin
    if (!i_rst_n) begin
      div_count <= DIV_RESET;
      state <= FPS_WAIT;
    end else if (i_sync) begin
      div_count <= DIV_RESET;
      state <= FPS_WAIT;
    end else if (sync_hold) begin
      div_count <= DIV_RESET;
      state <= FPS_WAIT;
    end else begin
      div_count <= (state == FPS_RUN) ? next_div : DIV_RESET;
      state <= next_state;
    end
  end

  // =====================================================
  // Shift chain and registered divided clocks
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      shift_chain <= SHIFT_RESET;
      o_clock_quarter_out <= 1'b0;
      o_clock_eighth_out <= 1'b0;
      o_load_pulse <= 1'b0;
      ready_reg <= 1'b0;
    end else begin
      shift_chain <= next_shift;
      o_clock_quarter_out <= div_count[1];
      o_clock_eighth_out <= div_count[2];
      o_load_pulse <= load_now;
      ready_reg <= fifo_bus.in_ready;
    end
  end

  // =====================================================
  // Serial output retimed on the falling edge; costs half a cycle
  always_ff @(negedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      serial_neg <= 1'b0;
    end else begin
      serial_neg <= shift_chain[0];
    end
  end

  assign o_serial_line_out = serial_neg;
  assign o_word_ready = ready_reg;

  fps_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .port(fifo_bus.fifo)
  );
endmodule
